/* design/wwr_window_watchdog.sv */
/*
  Window watchdog and reset sequencer with an Avalon-MM register slave.
  Assumes one 20 MHz clock, synchronous inputs, static select straps and
  an Avalon master that holds its request until waitrequest is low.
*/
// The implementer's own choices: the register offsets and register access over Avalon-MM.
// Behaviour
// (RULE_01) watchdog mode comes from the static levels of both select pins
// (RULE_02) LL fast, LH slow, HL fast, HH off; reset fast only for LL
// (RULE_03) reset hold is 16 ms for LL, 32 ms otherwise
// (RULE_04) after power-on reset output stays low for the hold time
// (RULE_05) rising reset output starts a 32 ms ignore window
// (RULE_06) trigger input is disregarded during the ignore window
// (RULE_07) ignore window is followed by a 128 ms long open window
// (RULE_08) valid trigger in the long open window starts a 32 ms closed window
// (RULE_09) a falling edge on the trigger input is the trigger event
// (RULE_10) valid trigger is two high then two low samples, 0.5 ms apart
// (RULE_11) closed window end starts a standard 32 ms open window
// (RULE_12) valid trigger in the open window ends it at once
// (RULE_13) no trigger before the open window expires asserts reset
// (RULE_14) a trigger during the closed window asserts reset
// (RULE_15) processor pulses the trigger at a steady period
// (RULE_16) suggested trigger period is closed time plus half open time
// (RULE_17) trigger ending an open window starts a new closed window
// (RULE_18) slow timing doubles ignore, closed, open and long open windows
// (RULE_19) watchdog reset holds then restarts at ignore; off means no resets
`timescale 1ns/1ps
module wwr_window_watchdog #(
  parameter int SAMPLE_CYCLES = wwr_pkg::SAMPLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic timingSelectA,
  input wire logic timingSelectB,
  input wire logic watchdogTriggerIn,
  output logic resetOutN,
  output logic irq,
  input wire logic [wwr_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // mode decode from the select straps
  function automatic wwr_pkg::wwr_mode_s decodeMode(input logic a,
                                                    input logic b);
    wwr_pkg::wwr_mode_s m;
    m.wdOff = a & b; // RULE_02
    m.wdSlow = ~a & b; // RULE_02
    m.rstSlow = a | b; // RULE_02 RULE_03
    return m;
  endfunction

  // doubles a fast duration when slow timing is chosen
  function automatic wwr_pkg::wwr_tick_t scaleTicks(
      input wwr_pkg::wwr_tick_t base, input logic slow);
    return slow ? base << wwr_pkg::SLOW_SHIFT : base; // RULE_18
  endfunction

  // length of the window belonging to a state, in sample ticks
  function automatic wwr_pkg::wwr_tick_t windowLimit(
      input wwr_pkg::wwr_state_e st, input wwr_pkg::wwr_mode_s m);
    wwr_pkg::wwr_tick_t lim;
    lim = scaleTicks(wwr_pkg::WINDOW_TICKS, m.wdSlow);
    if (st == wwr_pkg::ST_HOLD) begin
      lim = scaleTicks(wwr_pkg::HOLD_TICKS, m.rstSlow); // RULE_03
    end else if (st == wwr_pkg::ST_LONG_OPEN) begin
      lim = scaleTicks(wwr_pkg::LONG_OPEN_TICKS, m.wdSlow); // RULE_07
    end
    return lim;
  endfunction

  wwr_pkg::wwr_state_e state_reg;
  wwr_pkg::wwr_state_e state_next;
  wwr_pkg::wwr_tick_t tickCnt_reg;
  wwr_pkg::wwr_tick_t tickCnt_next;
  wwr_pkg::wwr_mode_s mode_reg;
  wwr_pkg::wwr_mode_s mode_next;
  logic resetOutN_reg;
  logic resetOutN_next;
  wwr_pkg::wwr_evt_s evt;
  wwr_pkg::wwr_tick_t limit;
  logic sampleTick;
  logic trigValid;
  logic samplerClear;
  logic windowDone;

  logic [wwr_pkg::EVT_W-1:0] status_reg;
  logic [wwr_pkg::EVT_W-1:0] status_next;
  logic [wwr_pkg::EVT_W-1:0] mask_reg;
  logic [wwr_pkg::EVT_W-1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic accept;

  // trigger sampler history is held cleared outside the watched windows
  assign samplerClear = (state_reg == wwr_pkg::ST_HOLD) ||
    (state_reg == wwr_pkg::ST_IGNORE) ||
    (state_reg == wwr_pkg::ST_IDLE); // RULE_06

  wwr_trigger_sampler #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
  ) sampler (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .clear(samplerClear),
    .trigIn(watchdogTriggerIn),
    .sampleTick(sampleTick),
    .validPulse(trigValid)
  );

  // window end detection
  always_comb begin
    limit = windowLimit(state_reg, mode_reg);
    windowDone = sampleTick && (tickCnt_reg == limit - wwr_pkg::TICK_ONE);
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    tickCnt_next = sampleTick ? tickCnt_reg + wwr_pkg::TICK_ONE : tickCnt_reg;
    mode_next = mode_reg;
    resetOutN_next = resetOutN_reg;
    evt = '0;
    unique case (state_reg)
      wwr_pkg::ST_HOLD: begin
        mode_next = decodeMode(timingSelectA, timingSelectB); // RULE_01
        resetOutN_next = 1'b0; // RULE_04
        if (windowDone) begin
          resetOutN_next = 1'b1; // RULE_04
          tickCnt_next = '0;
          // off mode never enters the watched windows
          state_next = mode_reg.wdOff ? wwr_pkg::ST_IDLE
                                      : wwr_pkg::ST_IGNORE; // RULE_05 RULE_19
        end
      end
      wwr_pkg::ST_IGNORE: begin
        if (windowDone) begin
          state_next = wwr_pkg::ST_LONG_OPEN; // RULE_07
          tickCnt_next = '0;
        end
      end
      wwr_pkg::ST_LONG_OPEN, wwr_pkg::ST_OPEN: begin
        if (trigValid) begin
          evt.validTrig = 1'b1;
          state_next = wwr_pkg::ST_CLOSED; // RULE_08 RULE_12 RULE_17
          tickCnt_next = '0;
        end else if (windowDone) begin
          evt.missedTrig = 1'b1;
          state_next = wwr_pkg::ST_HOLD; // RULE_13 RULE_19
          resetOutN_next = 1'b0;
          tickCnt_next = '0;
        end
      end
      wwr_pkg::ST_CLOSED: begin
        if (trigValid) begin
          evt.earlyTrig = 1'b1;
          state_next = wwr_pkg::ST_HOLD; // RULE_14 RULE_19
          resetOutN_next = 1'b0;
          tickCnt_next = '0;
        end else if (windowDone) begin
          state_next = wwr_pkg::ST_OPEN; // RULE_11
          tickCnt_next = '0;
        end
      end
      wwr_pkg::ST_IDLE: begin
        tickCnt_next = '0; // watchdog off, reset stays high
      end
      default: begin
        state_next = wwr_pkg::ST_HOLD;
        resetOutN_next = 1'b0;
        tickCnt_next = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= wwr_pkg::ST_HOLD;
      tickCnt_reg <= '0;
      mode_reg <= '0;
      resetOutN_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      tickCnt_reg <= tickCnt_next;
      mode_reg <= mode_next;
      resetOutN_reg <= resetOutN_next;
    end
  end

  // bus slave, status, mask and interrupt next values
  always_comb begin
    accept = (read || write) && !wait_reg;
    wait_next = !((read || write) && wait_reg);
    status_next = status_reg;
    mask_next = mask_reg;
    rdata_next = rdata_reg;
    if (accept && write && address == wwr_pkg::OFF_STATUS) begin
      status_next = status_reg & ~writedata[wwr_pkg::EVT_W-1:0];
    end
    if (accept && write && address == wwr_pkg::OFF_MASK) begin
      mask_next = writedata[wwr_pkg::EVT_W-1:0];
    end
    status_next = status_next | evt; // set wins over clear
    if ((read || write) && wait_reg) begin
      rdata_next = '0;
      if (read) begin
        unique case (address)
          wwr_pkg::OFF_STATUS: rdata_next = 32'(status_reg);
          wwr_pkg::OFF_MASK: rdata_next = 32'(mask_reg);
          wwr_pkg::OFF_STATE: begin
            rdata_next = 32'(state_reg);
            rdata_next[wwr_pkg::STATE_MODE_LSB +: wwr_pkg::EVT_W] =
              mode_reg;
            rdata_next[wwr_pkg::STATE_RSTOUT_BIT] = resetOutN_reg;
          end
          default: rdata_next = '0;
        endcase
      end
    end
    irq_next = |(status_next & mask_next);
  end

  // bus slave registers
  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else if (ce) begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign resetOutN = resetOutN_reg;
  assign irq = irq_reg;
  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;

  // reset output only falls while holding
  a_reset_fall_hold: assert property ( // RULE_04
    @(posedge clock) disable iff (rst)
    $fell(resetOutN_reg) |-> state_reg == wwr_pkg::ST_HOLD)
    else $error("reset output fell outside hold");

  // release of reset opens the ignore window or the idle state
  a_release_ignore: assert property ( // RULE_05
    @(posedge clock) disable iff (rst)
    $rose(resetOutN_reg) |-> state_reg == wwr_pkg::ST_IGNORE ||
      state_reg == wwr_pkg::ST_IDLE)
    else $error("reset release did not start ignore window");

  // hold length depends on reset timing
  a_hold_length: assert property ( // RULE_03
    @(posedge clock) disable iff (rst)
    state_reg == wwr_pkg::ST_HOLD |->
      tickCnt_reg < (mode_reg.rstSlow ?
        wwr_pkg::HOLD_TICKS << wwr_pkg::SLOW_SHIFT :
        wwr_pkg::HOLD_TICKS))
    else $error("hold counter beyond hold time");

  // no trigger is seen during the ignore window
  a_ignore_quiet: assert property ( // RULE_06
    @(posedge clock) disable iff (rst)
    state_reg == wwr_pkg::ST_IGNORE |-> !trigValid)
    else $error("trigger seen in ignore window");

  // trigger in long open window starts closed window
  a_long_to_closed: assert property ( // RULE_08
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_LONG_OPEN && trigValid |=>
      state_reg == wwr_pkg::ST_CLOSED && tickCnt_reg == '0)
    else $error("long open trigger did not close window");

  // early trigger asserts reset
  a_closed_early: assert property ( // RULE_14
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_CLOSED && trigValid |=>
      !resetOutN_reg && status_reg[wwr_pkg::EVT_W-1])
    else $error("early trigger did not assert reset");

  // trigger in open window starts a new closed window
  a_open_to_closed: assert property ( // RULE_12
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_OPEN && trigValid |=>
      state_reg == wwr_pkg::ST_CLOSED)
    else $error("open window trigger did not close window");

  // missed trigger asserts reset for at least two cycles
  a_open_missed: assert property ( // RULE_13
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_OPEN && windowDone && !trigValid |=>
      !resetOutN_reg ##1 !resetOutN_reg)
    else $error("missed trigger did not assert reset");

  // closed window expiry opens the standard window
  a_closed_to_open: assert property ( // RULE_11
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_CLOSED && windowDone && !trigValid |=>
      state_reg == wwr_pkg::ST_OPEN)
    else $error("closed window did not open window");

  // watchdog off never resets after the first hold
  a_off_no_reset: assert property ( // RULE_19
    @(posedge clock) disable iff (rst)
    state_reg == wwr_pkg::ST_IDLE |=> resetOutN_reg)
    else $error("reset asserted with watchdog off");

  // long open window running out asserts reset
  a_long_missed: assert property ( // RULE_07
    @(posedge clock) disable iff (rst)
    ce && state_reg == wwr_pkg::ST_LONG_OPEN && windowDone && !trigValid |=>
      state_reg == wwr_pkg::ST_HOLD && !resetOutN_reg)
    else $error("long open expiry did not assert reset");

  // long open window never outlasts four standard windows
  a_long_bound: assert property ( // RULE_07 RULE_18
    @(posedge clock) disable iff (rst)
    state_reg == wwr_pkg::ST_LONG_OPEN |->
      tickCnt_reg < (mode_reg.wdSlow ?
        wwr_pkg::LONG_OPEN_TICKS << wwr_pkg::SLOW_SHIFT :
        wwr_pkg::LONG_OPEN_TICKS))
    else $error("long open counter beyond its limit");

  // closed and open windows never outlast one standard window
  a_window_bound: assert property ( // RULE_11 RULE_18
    @(posedge clock) disable iff (rst)
    state_reg == wwr_pkg::ST_CLOSED || state_reg == wwr_pkg::ST_OPEN |->
      tickCnt_reg < (mode_reg.wdSlow ?
        wwr_pkg::WINDOW_TICKS << wwr_pkg::SLOW_SHIFT :
        wwr_pkg::WINDOW_TICKS))
    else $error("window counter beyond its limit");

  // interrupt level follows masked status
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    irq_reg == |(status_reg & mask_reg))
    else $error("interrupt disagrees with status and mask");

endmodule

/* pkg/wwr_pkg.sv */
/*
  Constants, types and register map of the window watchdog and reset
  sequencer. Assumes a 20 MHz system clock and a 32-bit Avalon-MM slave.
*/
package wwr_pkg;

  // clock and sampling timebase
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_US = 500;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W = 14;

  // nominal fast-timing durations
  localparam int HOLD_FAST_US = 16000;
  localparam int WINDOW_FAST_US = 32000;
  localparam int LONG_OPEN_FACTOR = 4;
  localparam int SLOW_SHIFT = 1;

  // window lengths counted in sample ticks
  localparam int TICK_W = 10;
  typedef logic [TICK_W-1:0] wwr_tick_t;
  localparam wwr_tick_t HOLD_TICKS =
    wwr_tick_t'(HOLD_FAST_US / SAMPLE_PERIOD_US);
  localparam wwr_tick_t WINDOW_TICKS =
    wwr_tick_t'(WINDOW_FAST_US / SAMPLE_PERIOD_US);
  localparam wwr_tick_t LONG_OPEN_TICKS =
    wwr_tick_t'(LONG_OPEN_FACTOR * WINDOW_FAST_US / SAMPLE_PERIOD_US);
  localparam wwr_tick_t TICK_ONE = 10'h001;

  // trigger pattern, oldest sample in the top bit: high, high, low, low
  localparam int HIST_W = 4;
  localparam logic [HIST_W-1:0] TRIG_PATTERN = 4'hC;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_IGNORE,
    ST_LONG_OPEN,
    ST_CLOSED,
    ST_OPEN,
    ST_IDLE
  } wwr_state_e;

  typedef struct packed {
    logic wdOff;
    logic wdSlow;
    logic rstSlow;
  } wwr_mode_s;

  typedef struct packed {
    logic earlyTrig;
    logic missedTrig;
    logic validTrig;
  } wwr_evt_s;

  localparam int EVT_W = 3;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATE = 4'h8;
  localparam int STATE_MODE_LSB = 4;
  localparam int STATE_RSTOUT_BIT = 8;

endpackage

/* design/wwr_trigger_sampler.sv */
/*
  Trigger sampler: divides the clock into 0.5 ms sample ticks and looks
  for two high samples followed by two low samples on the trigger input.
  Assumes the trigger input is synchronous to clock.
*/
`timescale 1ns/1ps
module wwr_trigger_sampler #(
  parameter int SAMPLE_CYCLES = wwr_pkg::SAMPLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic trigIn,
  output logic sampleTick,
  output logic validPulse
);

  logic [wwr_pkg::SAMPLE_CNT_W-1:0] div_reg;
  logic [wwr_pkg::SAMPLE_CNT_W-1:0] div_next;
  logic [wwr_pkg::HIST_W-1:0] hist_reg;
  logic [wwr_pkg::HIST_W-1:0] hist_next;
  logic tick_reg;
  logic tick_next;
  logic valid_reg;
  logic valid_next;
  logic tickNow;

  localparam int DIV_LAST_INT = SAMPLE_CYCLES - 1;
  localparam logic [wwr_pkg::SAMPLE_CNT_W-1:0] DIV_LAST =
    DIV_LAST_INT[wwr_pkg::SAMPLE_CNT_W-1:0];

  // divider and sample history
  always_comb begin
    tickNow = (div_reg == DIV_LAST);
    div_next = tickNow ? '0 : div_reg + 1'b1;
    tick_next = tickNow;
    hist_next = hist_reg;
    valid_next = 1'b0;
    if (clear) begin
      hist_next = '0; // RULE_06
    end else if (tickNow) begin
      hist_next = {hist_reg[wwr_pkg::HIST_W-2:0], trigIn};
      valid_next = ({hist_reg[wwr_pkg::HIST_W-2:0], trigIn} ==
        wwr_pkg::TRIG_PATTERN); // RULE_09 RULE_10
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_reg <= '0;
      hist_reg <= '0;
      tick_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      div_reg <= div_next;
      hist_reg <= hist_next;
      tick_reg <= tick_next;
      valid_reg <= valid_next;
    end
  end

  assign sampleTick = tick_reg;
  assign validPulse = valid_reg;

  // a valid pulse only follows a full high-high-low-low history
  a_pattern_pulse: assert property ( // RULE_10
    @(posedge clock) disable iff (rst)
    valid_reg |-> hist_reg == wwr_pkg::TRIG_PATTERN && tick_reg)
    else $error("trigger pulse without matching samples");

endmodule

/* sim/wwr_cpu_model.sv */
/*
  Processor model on the far side of the watchdog: takes the reset output
  and pulses the trigger line low at a period set by the bench.
  Assumes the bench changes the period only between pulses.
*/
`timescale 1ns/1ps
module wwr_cpu_model #(
  parameter int SAMPLE_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic resetOutN,
  input wire integer period,
  output logic trigOut
);
  int cnt;
  int lowLeft;

  // processor in reset keeps the line high and restarts its period
  always @(posedge clock) begin
    if (rst || resetOutN !== 1'b1) begin
      cnt <= 0;
      lowLeft <= 0;
    end else begin
      cnt <= cnt + 1;
      if (lowLeft > 0) lowLeft <= lowLeft - 1;
      if (period > 0 && cnt + 1 >= period) begin
        cnt <= 0;
        lowLeft <= 3 * SAMPLE_CYCLES;
      end
    end
  end

  // line is high between pulses, so two high samples precede each pulse
  assign trigOut = (lowLeft == 0);
endmodule

/* sim/window_watchdog_reset_tb.sv */
/*
  Testbench of the window watchdog: strap table, trigger windows,
  missed and early triggers, status, mask and interrupt registers.
  Assumes the processor model and a sample tick of SC clocks.
*/
`timescale 1ns/1ps
module window_watchdog_reset_tb;
  localparam int SC = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic timingSelectA = 1'b0;
  logic timingSelectB = 1'b0;
  logic trig;
  logic resetOutN;
  logic irq;
  logic [wwr_pkg::ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  int period = 0;
  int errors = 0;
  int n_compared = 0;
  // columns: strap a, strap b, hold ticks, state word, mask, period ticks
  int tbl[4][6] = '{'{0, 0, 32, 'h101, 'h177, 96},
                    '{0, 1, 64, 'h131, 'h177, 192},
                    '{1, 0, 64, 'h111, 'h177, 96},
                    '{1, 1, 64, 'h155, 'h157, 0}};

  // clock of 50 ns period
  always #25 clock = ~clock;

  wwr_window_watchdog #(.SAMPLE_CYCLES(SC)) dut (
    .clock(clock), .rst(rst), .ce(ce),
    .timingSelectA(timingSelectA), .timingSelectB(timingSelectB),
    .watchdogTriggerIn(trig), .resetOutN(resetOutN), .irq(irq),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest)
  );

  wwr_cpu_model #(.SAMPLE_CYCLES(SC)) cpu (
    .clock(clock), .rst(rst), .resetOutN(resetOutN),
    .period(period), .trigOut(trig)
  );

  task test_done;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t value %h, expected %h", $time, got, exp);
    end
  endtask

  task chk_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // one Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("[FAIL] %0t bus access timed out", $time);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // cycles until the reset output reaches a level
  task wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (resetOutN !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask

  // reset with given straps, return the hold length in clocks
  task start(input logic a, input logic b, output int hold);
    @(posedge clock);
    timingSelectA <= a;
    timingSelectB <= b;
    period <= 0;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    wait_lvl(1'b1, 4000, hold);
  endtask

  // watchdog against a hung run
  initial begin
    repeat (80000) @(posedge clock);
    errors++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done;
  end

  // strap table, then ignore, missed, early and register cases
  initial begin
    int h;
    int f;
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      start(tbl[i][0], tbl[i][1], h);
      chk_range(h, tbl[i][2] * SC - 8, tbl[i][2] * SC + 8);
      period <= tbl[i][5] * SC;
      bus(1'b0, wwr_pkg::OFF_STATE, 32'h0, q);
      chk_val(q & 32'(tbl[i][4]), 32'(tbl[i][3]));
      f = 0;
      repeat (7000) begin
        @(posedge clock);
        if (resetOutN !== 1'b1) f++;
      end
      chk_val(f, 0);
      bus(1'b0, wwr_pkg::OFF_STATUS, 32'h0, q);
      chk_val(q & 32'h7, 32'(tbl[i][5] != 0));
    end
    // pulse inside the ignore window, then silence in the long open
    start(1'b0, 1'b0, h);
    period <= 37 * SC;
    repeat (50 * SC) @(posedge clock);
    period <= 0;
    repeat (200 * SC) @(posedge clock);
    bus(1'b0, wwr_pkg::OFF_STATE, 32'h0, q);
    chk_val(q & 32'h107, 32'h102);
    // long open window runs out 320 ticks after release
    wait_lvl(1'b0, 400 * SC, f);
    chk_range(f, 66 * SC, 72 * SC);
    // one trigger, then none: open window runs out
    start(1'b0, 1'b0, h);
    period <= 96 * SC;
    repeat (120 * SC) @(posedge clock);
    period <= 0;
    wait_lvl(1'b0, 400 * SC, f);
    chk_range(f, 100 * SC, 114 * SC);
    wait_lvl(1'b1, 400 * SC, h);
    chk_range(h, 32 * SC - 8, 32 * SC + 8);
    bus(1'b0, wwr_pkg::OFF_STATE, 32'h0, q);
    chk_val(q & 32'h107, 32'h101);
    bus(1'b0, wwr_pkg::OFF_STATUS, 32'h0, q);
    chk_val(q & 32'h2, 32'h2);
    // mask, interrupt level, write-one-to-clear, unmapped address
    bus(1'b1, wwr_pkg::OFF_MASK, 32'h2, q);
    bus(1'b0, wwr_pkg::OFF_MASK, 32'h0, q);
    chk_val(q, 32'h2);
    repeat (3) @(posedge clock);
    chk_val({31'h0, irq}, 32'h1);
    bus(1'b1, wwr_pkg::OFF_STATUS, 32'h2, q);
    repeat (3) @(posedge clock);
    chk_val({31'h0, irq}, 32'h0);
    bus(1'b0, wwr_pkg::OFF_STATUS, 32'h0, q);
    chk_val(q & 32'h2, 32'h0);
    bus(1'b0, 4'hC, 32'h0, q);
    chk_val(q, 32'h0);
    // second pulse lands inside the closed window
    start(1'b0, 1'b0, h);
    period <= 96 * SC;
    repeat (110 * SC) @(posedge clock);
    period <= 30 * SC;
    wait_lvl(1'b0, 100 * SC, f);
    period <= 0;
    chk_range(f, 14 * SC, 24 * SC);
    bus(1'b0, wwr_pkg::OFF_STATUS, 32'h0, q);
    chk_val(q & 32'h4, 32'h4);
    // clock enable low freezes the hold countdown
    ce <= 1'b0;
    repeat (200) @(posedge clock);
    chk_val({31'h0, resetOutN}, 32'h0);
    ce <= 1'b1;
    wait_lvl(1'b1, 400 * SC, h);
    chk_range(h, 32 * SC - 8, 32 * SC + 8);
    test_done;
  end
endmodule
